// *** cfg_port_defs.svh ***
`ifndef CFG_PORT_DEFS_SVH
`define CFG_PORT_DEFS_SVH

// ==========================================================
// Clock and timing
`define CFG_CLK_PERIOD_NS 40
`define RCLK_HALF_NS 80
`define RCLK_HALF_CYC ((`RCLK_HALF_NS + `CFG_CLK_PERIOD_NS - 1) / `CFG_CLK_PERIOD_NS)

// ==========================================================
// Bit positions in the synchronised pin vector
`define PIN_W 36
`define PIN_CS_LO 0
`define PIN_CS_HI 1
`define PIN_STRB 2
`define PIN_RNW 3
`define PIN_BURST 4
`define PIN_INIT 5
`define PIN_DATA_LSB 6
`define PIN_DATA_MSB 13
`define PIN_ADDR_LSB 14
`define PIN_ADDR_MSB 31
`define PIN_MODE_LSB 32
`define PIN_MODE_MSB 35

// ==========================================================
// Reset values (pins idle high through pull-ups)
`define PIN_RST 36'hF_FFFF_FFFF
`define MODE_RST 4'hF
`define DATA_RST 8'h00

// ==========================================================
// Mode pin codes (arbitrary assignment)
`define MODE_CODE_ASYNC 4'h5
`define MODE_CODE_SLAVE_PAR 4'h7
`define MODE_CODE_MASTER_PAR 4'h6
`define MODE_CODE_PROC 4'h3

`endif

// *** cfg_port_pkg.sv ***
package cfg_port_pkg;

   // Loader sequence, Gray coded along the path
   typedef enum logic [1:0] {
      ST_CLEAR = 2'h0,
      ST_WAIT = 2'h1,
      ST_CONFIG = 2'h3,
      ST_DONE = 2'h2
   } cfg_state_e;

   // Configuration modes chosen by the mode pins
   typedef enum logic [2:0] {
      MODE_OTHER = 3'h0,
      MODE_ASYNC = 3'h1,
      MODE_SLAVE_PAR = 3'h2,
      MODE_MASTER_PAR = 3'h3,
      MODE_PROC = 3'h4
   } cfg_mode_e;

endpackage

// *** cfg_host_port.sv ***
`timescale 1ns/1ps
`include "cfg_port_defs.svh"
`default_nettype none

module cfg_host_port #(
   parameter int ADDR_W = 18,
   parameter int DATA_W = 8
) (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic [3:0] mode_sel_in,
   input wire logic init_n_in,
   output logic init_n_out,
   output logic init_n_oe_out,
   input wire logic mem_clear_busy_in,
   input wire logic cfg_done_in,
   input wire logic cfg_restart_in,
   input wire logic bscan_selected_in,
   input wire logic chip_select_low_active_in,
   input wire logic chip_select_high_active_in,
   input wire logic host_transfer_strobe_in,
   input wire logic host_read_not_write_in,
   input wire logic [ADDR_W-1:0] host_address_lsbs_in,
   input wire logic host_burst_n_in,
   input wire logic [DATA_W-1:0] data_in,
   output logic [DATA_W-1:0] data_out,
   output logic [DATA_W-1:0] data_oe_out,
   output logic rdy_rclk_out,
   output logic cfg_active_high_flag_out,
   output logic cfg_active_low_flag_out,
   output logic bscan_enable_out,
   output logic host_req_valid_out,
   output logic host_req_read_out,
   output logic host_req_burst_out,
   output logic [ADDR_W-1:0] host_req_addr_out,
   output logic [DATA_W-1:0] cfg_byte_out,
   output logic cfg_byte_valid_out,
   input wire logic cfg_byte_ready_in
);

   // ==========================================================
   // Pin synchronisers
   logic [`PIN_W-1:0] pin_raw;
   logic [`PIN_W-1:0] s1_r;
   logic [`PIN_W-1:0] s2_r;
   logic [`PIN_W-1:0] s3_r;
   logic [`PIN_W-1:0] filt_r;
   logic [2:0] prev_r;

   assign pin_raw = {mode_sel_in, host_address_lsbs_in, data_in, init_n_in, host_burst_n_in,
                     host_read_not_write_in, host_transfer_strobe_in,
                     chip_select_high_active_in, chip_select_low_active_in};

   // Three stages, then a bit changes once stages two and three agree
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         s1_r <= `PIN_RST;
         s2_r <= `PIN_RST;
         s3_r <= `PIN_RST;
         filt_r <= `PIN_RST;
      end else begin
         s1_r <= pin_raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
         filt_r <= (s2_r & s3_r) | (filt_r & (s2_r | s3_r));
      end
   end

   logic cs_lo_f, cs_hi_f, strb_n_f, rnw_f, burst_n_f, init_f;
   logic [DATA_W-1:0] data_f;
   logic [3:0] mode_f;
   assign cs_lo_f = filt_r[`PIN_CS_LO];
   assign cs_hi_f = filt_r[`PIN_CS_HI];
   assign strb_n_f = filt_r[`PIN_STRB];
   assign rnw_f = filt_r[`PIN_RNW];
   assign burst_n_f = filt_r[`PIN_BURST];
   assign init_f = filt_r[`PIN_INIT];
   assign data_f = filt_r[`PIN_DATA_MSB:`PIN_DATA_LSB];
   assign mode_f = filt_r[`PIN_MODE_MSB:`PIN_MODE_LSB];

   // Previous strobe, write and init levels for edge detection
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         prev_r <= 3'h7;
      end else begin
         prev_r <= {init_f, rnw_f, strb_n_f};
      end
   end

   logic selected;
   logic init_rise;
   logic wr_fall;
   logic strb_fall;
   assign selected = !cs_lo_f && cs_hi_f;
   assign init_rise = init_f && !prev_r[2];
   assign wr_fall = !rnw_f && prev_r[1];
   assign strb_fall = !strb_n_f && prev_r[0];

   // ==========================================================
   // Mode capture and decode
   function automatic cfg_port_pkg::cfg_mode_e decode_mode(input logic [3:0] code);
      case (code)
         `MODE_CODE_ASYNC: decode_mode = cfg_port_pkg::MODE_ASYNC;
         `MODE_CODE_SLAVE_PAR: decode_mode = cfg_port_pkg::MODE_SLAVE_PAR;
         `MODE_CODE_MASTER_PAR: decode_mode = cfg_port_pkg::MODE_MASTER_PAR;
         `MODE_CODE_PROC: decode_mode = cfg_port_pkg::MODE_PROC;
         default: decode_mode = cfg_port_pkg::MODE_OTHER;
      endcase
   endfunction

   logic [3:0] mode_r;
   cfg_port_pkg::cfg_mode_e mode;
   cfg_port_pkg::cfg_state_e state_r;
   cfg_port_pkg::cfg_state_e state_nxt;
   assign mode = decode_mode(mode_r);

   // Latch mode pins as the initialization line rises
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         mode_r <= `MODE_RST;
      end else if (state_r == cfg_port_pkg::ST_WAIT && init_rise) begin
         mode_r <= mode_f;
      end
   end

   // ==========================================================
   // Loader sequence
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         cfg_port_pkg::ST_CLEAR: begin
            if (!mem_clear_busy_in) begin
               state_nxt = cfg_port_pkg::ST_WAIT;
            end
         end
         cfg_port_pkg::ST_WAIT: begin
            if (init_rise) begin
               state_nxt = cfg_port_pkg::ST_CONFIG;
            end
         end
         cfg_port_pkg::ST_CONFIG: begin
            if (cfg_done_in) begin
               state_nxt = cfg_port_pkg::ST_DONE;
            end
         end
         cfg_port_pkg::ST_DONE: begin
            state_nxt = cfg_port_pkg::ST_DONE;
         end
         default: state_nxt = cfg_port_pkg::ST_CLEAR;
      endcase
      if (cfg_restart_in) begin
         state_nxt = cfg_port_pkg::ST_CLEAR;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         state_r <= cfg_port_pkg::ST_CLEAR;
      end else begin
         state_r <= state_nxt;
      end
   end

   logic in_cfg;
   logic byte_mode;
   assign in_cfg = (state_r == cfg_port_pkg::ST_CONFIG);
   assign byte_mode = (mode == cfg_port_pkg::MODE_ASYNC) || (mode == cfg_port_pkg::MODE_SLAVE_PAR);

   // Open-drain init: pull low only while clearing
   assign init_n_out = 1'b0;
   assign init_n_oe_out = (state_r == cfg_port_pkg::ST_CLEAR);

   // In-progress flags and scan enable
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         cfg_active_high_flag_out <= 1'b1;
         cfg_active_low_flag_out <= 1'b0;
         bscan_enable_out <= 1'b1;
      end else begin
         cfg_active_high_flag_out <= (state_nxt != cfg_port_pkg::ST_DONE);
         cfg_active_low_flag_out <= (state_nxt == cfg_port_pkg::ST_DONE);
         bscan_enable_out <= (state_nxt != cfg_port_pkg::ST_DONE) || bscan_selected_in;
      end
   end

   // ==========================================================
   // Processor port request decode
   logic proc_hit;
   assign proc_hit = in_cfg && (mode == cfg_port_pkg::MODE_PROC) && selected && strb_fall;

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         host_req_valid_out <= 1'b0;
         host_req_read_out <= 1'b0;
         host_req_burst_out <= 1'b0;
         host_req_addr_out <= '0;
      end else begin
         host_req_valid_out <= proc_hit;
         if (proc_hit) begin
            host_req_read_out <= rnw_f;
            host_req_burst_out <= !burst_n_f;
            host_req_addr_out <= filt_r[`PIN_ADDR_MSB:`PIN_ADDR_LSB];
         end
      end
   end

   // ==========================================================
   // Byte intake: host writes, processor writes, master reads
   logic pend_valid_r;
   logic [DATA_W-1:0] pend_data_r;
   logic buf_in_ready;
   logic byte_wr;
   logic master_fetch;
   logic rclk_r;
   logic [7:0] rclk_cnt_r;
   logic master_mode;

   assign master_mode = in_cfg && (mode == cfg_port_pkg::MODE_MASTER_PAR);
   assign byte_wr = in_cfg && selected && ((byte_mode && wr_fall) || (proc_hit && !rnw_f));
   assign master_fetch = master_mode && !pend_valid_r && !rclk_r &&
                         rclk_cnt_r == 8'(`RCLK_HALF_CYC - 1);

   // One byte per write-line fall, processor write strobe or master read clock fetch, held until the buffer takes it
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         pend_valid_r <= 1'b0;
         pend_data_r <= `DATA_RST;
      end else if (byte_wr || master_fetch) begin
         pend_valid_r <= 1'b1;
         pend_data_r <= data_f;
      end else if (buf_in_ready) begin
         pend_valid_r <= 1'b0;
      end
   end

   // Read clock divider, stalled while a byte waits
   always_ff @(posedge clk_in) begin
      if (srst_in || !master_mode) begin
         rclk_r <= 1'b1;
         rclk_cnt_r <= 8'h00;
      end else if (rclk_cnt_r == 8'(`RCLK_HALF_CYC - 1)) begin
         if (rclk_r || !pend_valid_r) begin
            rclk_r <= !rclk_r;
            rclk_cnt_r <= 8'h00;
         end
      end else begin
         rclk_cnt_r <= rclk_cnt_r + 8'h01;
      end
   end

   // Ready: high when idle and write line released
   logic rdy_r;
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         rdy_r <= 1'b0;
      end else begin
         rdy_r <= in_cfg && !pend_valid_r && !byte_wr && rnw_f;
      end
   end

   assign rdy_rclk_out = master_mode ? rclk_r : rdy_r;

   // ==========================================================
   // Two-entry buffer toward the configuration engine
   logic [DATA_W-1:0] buf_mem [0:1];
   logic buf_wp_r;
   logic buf_rp_r;
   logic [1:0] buf_cnt_r;
   logic buf_push;
   logic buf_pop;

   assign buf_in_ready = (buf_cnt_r != 2'h2);
   assign buf_push = pend_valid_r && buf_in_ready;
   assign buf_pop = cfg_byte_valid_out && cfg_byte_ready_in;
   assign cfg_byte_valid_out = (buf_cnt_r != 2'h0);
   assign cfg_byte_out = buf_mem[buf_rp_r];

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         buf_mem[0] <= `DATA_RST;
         buf_mem[1] <= `DATA_RST;
      end else if (buf_push) begin
         buf_mem[buf_wp_r] <= pend_data_r;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         buf_wp_r <= 1'b0;
         buf_rp_r <= 1'b0;
         buf_cnt_r <= 2'h0;
      end else begin
         buf_wp_r <= buf_wp_r ^ buf_push;
         buf_rp_r <= buf_rp_r ^ buf_pop;
         buf_cnt_r <= buf_cnt_r + {1'b0, buf_push} - {1'b0, buf_pop};
      end
   end

   // ==========================================================
   // Status readback on the upper data lines
   logic status_drive;
   assign status_drive = in_cfg && (mode == cfg_port_pkg::MODE_ASYNC) && selected &&
                         !strb_n_f && rnw_f;
   assign data_oe_out = status_drive ? 8'hF8 : 8'h00;

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         data_out <= `DATA_RST;
      end else begin
         data_out <= {rdy_r, !buf_in_ready, pend_valid_r, state_r, 3'h0};
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);

   a_mode_latched: assert property (state_r == cfg_port_pkg::ST_WAIT && init_rise && !cfg_restart_in
      |=> mode_r == $past(mode_f) && state_r == cfg_port_pkg::ST_CONFIG)
      else $error("mode not latched at init rise");
   a_select_gate: assert property (data_oe_out != 8'h00 |-> !cs_lo_f && cs_hi_f)
      else $error("status driven while not selected");
   a_status_lines: assert property (in_cfg && mode == cfg_port_pkg::MODE_ASYNC && selected
      && !strb_n_f && rnw_f |-> data_oe_out == 8'hF8)
      else $error("status lines not driven on read");
   a_write_wins: assert property (!strb_n_f && !rnw_f |-> data_oe_out == 8'h00)
      else $error("read drive during write");
   a_byte_load: assert property (in_cfg && byte_mode && selected && wr_fall && !cfg_restart_in
      |=> pend_valid_r && pend_data_r == $past(data_f))
      else $error("written byte not loaded");
   a_busy_write: assert property (byte_wr |=> !rdy_r ##1 !rdy_r)
      else $error("ready during byte intake");
   a_ready_bit: assert property (status_drive |=> data_out[7] == $past(rdy_r))
      else $error("ready copy on data bit 7 wrong");
   a_rclk_only: assert property (!master_mode |-> rdy_rclk_out == rdy_r)
      else $error("read clock outside master mode");
   a_flags_pair: assert property ((cfg_active_high_flag_out == !cfg_active_low_flag_out)
      and (state_r == cfg_port_pkg::ST_CONFIG |-> cfg_active_high_flag_out))
      else $error("in-progress flags disagree");
   a_init_pull: assert property (state_r == cfg_port_pkg::ST_CLEAR |-> init_n_oe_out)
      else $error("init not pulled during clear");
   a_wait_hold: assert property (state_r == cfg_port_pkg::ST_WAIT && !init_f
      |=> state_r != cfg_port_pkg::ST_CONFIG)
      else $error("started while init low");
   a_scan_off: assert property (state_r == cfg_port_pkg::ST_DONE && !cfg_restart_in
      && !bscan_selected_in |=> !bscan_enable_out)
      else $error("scan left enabled");
   a_proc_dir: assert property (proc_hit |=> host_req_valid_out
      && host_req_read_out == $past(rnw_f))
      else $error("processor direction wrong");

   c_async_write: cover property (byte_wr ##[1:4] cfg_byte_valid_out);
   c_status_read: cover property (status_drive);
   c_buffer_full: cover property (!buf_in_ready && pend_valid_r);
   c_master_fetch: cover property (master_fetch);

endmodule

`default_nettype wire

// *** cfg_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Host processor model at the configuration pins
module cfg_host_model (
   input wire logic clk_in,
   input wire logic rdy_in,
   output logic cs_lo_out,
   output logic cs_hi_out,
   output logic rd_n_out,
   output logic wr_n_out,
   output logic [7:0] d_out,
   output logic d_oe_out,
   output logic init_hold_out,
   output logic [17:0] addr_out,
   output logic burst_n_out,
   output logic tms_out
);
   // Idle levels: deselected, strobes high, bus released
   initial begin
      cs_lo_out = 1'b1;
      cs_hi_out = 1'b0;
      rd_n_out = 1'b1;
      wr_n_out = 1'b1;
      d_out = 8'h00;
      d_oe_out = 1'b0;
      init_hold_out = 1'b0;
      addr_out = 18'h00000;
      burst_n_out = 1'b1;
      tms_out = 1'b1;
   end

   // Init line held low from outside, or released
   task automatic hold_init(input logic v);
      init_hold_out = v;
   endtask

   // Select and strobe levels in one step
   task automatic strobes(input logic sel, input logic rd_n, input logic wr_n);
      cs_lo_out = ~sel;
      cs_hi_out = sel;
      rd_n_out = rd_n;
      wr_n_out = wr_n;
   endtask

   // Byte write held past the pin filter, optionally paced on ready
   task automatic write_byte(input logic [7:0] b, input logic sel, input logic pace);
      int i;
      d_out = b;
      d_oe_out = 1'b1;
      strobes(sel, 1'b1, 1'b0);
      repeat (6) @(negedge clk_in);
      strobes(sel, 1'b1, 1'b1);
      @(negedge clk_in);
      d_oe_out = 1'b0;
      strobes(1'b0, 1'b1, 1'b1);
      for (i = 0; i < 40 && pace && rdy_in !== 1'b1; i++) begin
         @(negedge clk_in);
      end
   endtask

   // Processor strobe with direction, address and burst
   task automatic proc_xfer(input logic rnw, input logic [17:0] a, input logic bn);
      addr_out = a;
      burst_n_out = bn;
      strobes(1'b1, 1'b0, rnw);
      repeat (6) @(negedge clk_in);
      strobes(1'b0, 1'b1, 1'b1);
      repeat (6) @(negedge clk_in);
   endtask
endmodule
`default_nettype wire

// *** fpga_config_host_port_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) begin \
   cmp_count++; \
   if ((act) !== (exp)) begin \
      error_cnt++; \
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, act, exp); \
   end \
end
// ==========================================================
// Testbench top
module fpga_config_host_port_tb;
   logic clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic [3:0] mode_sel = 4'hF;
   logic mem_clear_busy = 1'b1;
   logic cfg_done = 1'b0;
   logic cfg_restart = 1'b0;
   logic sink_ready = 1'b1;
   logic bscan_sel = 1'b0;
   logic req_burst;
   int error_cnt = 0;
   int cmp_count = 0;
   int req_cnt = 0;
   logic req_rd;
   logic [17:0] req_addr;
   logic [7:0] got[$];
   wire logic cs_lo, cs_hi, rd_n, wr_n, h_oe, init_hold, burst_n;
   wire logic [7:0] h_d, data_out, data_oe;
   wire logic [17:0] h_addr, req_addr_w;
   wire logic init_n_out, init_n_oe, rdy, flag_hi, flag_lo, bscan_en;
   wire logic req_valid, req_read, cfg_valid, req_burst_w, tms;
   wire logic [7:0] cfg_byte;
   wire logic [7:0] data_pin;
   wire logic init_pin;

   // Pin resolution: pull-ups on data and init lines
   assign data_pin = (data_oe & data_out) | (~data_oe & (h_oe ? h_d : 8'hFF));
   assign init_pin = ~(init_n_oe & ~init_n_out) & ~init_hold;

   // Clock generation
   initial begin
      forever #20 clk_in = ~clk_in;
   end

   cfg_host_model host (.clk_in(clk_in), .rdy_in(rdy), .cs_lo_out(cs_lo), .cs_hi_out(cs_hi),
      .rd_n_out(rd_n), .wr_n_out(wr_n), .d_out(h_d), .d_oe_out(h_oe),
      .init_hold_out(init_hold), .addr_out(h_addr), .burst_n_out(burst_n), .tms_out(tms));

   cfg_host_port dut (.clk_in(clk_in), .srst_in(srst_in), .mode_sel_in(mode_sel),
      .init_n_in(init_pin), .init_n_out(init_n_out), .init_n_oe_out(init_n_oe),
      .mem_clear_busy_in(mem_clear_busy), .cfg_done_in(cfg_done),
      .cfg_restart_in(cfg_restart), .bscan_selected_in(bscan_sel),
      .chip_select_low_active_in(cs_lo), .chip_select_high_active_in(cs_hi),
      .host_transfer_strobe_in(rd_n), .host_read_not_write_in(wr_n),
      .host_address_lsbs_in(h_addr), .host_burst_n_in(burst_n), .data_in(data_pin),
      .data_out(data_out), .data_oe_out(data_oe), .rdy_rclk_out(rdy),
      .cfg_active_high_flag_out(flag_hi), .cfg_active_low_flag_out(flag_lo),
      .bscan_enable_out(bscan_en), .host_req_valid_out(req_valid),
      .host_req_read_out(req_read), .host_req_burst_out(req_burst_w),
      .host_req_addr_out(req_addr_w), .cfg_byte_out(cfg_byte),
      .cfg_byte_valid_out(cfg_valid), .cfg_byte_ready_in(sink_ready));

   // Sink and processor request capture
   always @(posedge clk_in) begin
      if (cfg_valid === 1'b1 && sink_ready) got.push_back(cfg_byte);
      if (req_valid === 1'b1) begin
         req_cnt++;
         req_rd = req_read;
         req_burst = req_burst_w;
         req_addr = req_addr_w;
      end
   end

   // Restart through clear and wait into configuration
   task automatic start_cfg(input logic [3:0] m);
      mode_sel = m;
      cfg_restart = 1'b1;
      mem_clear_busy = 1'b1;
      @(negedge clk_in);
      cfg_restart = 1'b0;
      repeat (4) @(negedge clk_in);
      `CHK(init_n_oe, 1'b1)
      mem_clear_busy = 1'b0;
      repeat (12) @(negedge clk_in);
      `CHK({flag_hi, flag_lo}, 2'b10)
      `CHK(tms, 1'b1)
   endtask

   // Outputs while reset is still held
   task automatic t_reset();
      `CHK(init_n_oe, 1'b1)
      `CHK({flag_hi, flag_lo, rdy}, 3'b100)
   endtask

   // Init held low blocks intake; async write after release
   task automatic t_hold_write();
      host.hold_init(1'b1);
      start_cfg(4'h5);
      host.write_byte(8'h3C, 1'b1, 1'b0);
      `CHK(got.size(), 0)
      host.hold_init(1'b0);
      repeat (10) @(negedge clk_in);
      mode_sel = 4'hF;
      host.write_byte(8'hA5, 1'b1, 1'b1);
      `CHK(got.size(), 1)
      `CHK(got[0], 8'hA5)
      host.write_byte(8'h11, 1'b0, 1'b1);
      `CHK(got.size(), 1)
   endtask

   // Status read, deselected read, and read with write together
   task automatic t_status();
      host.strobes(1'b1, 1'b0, 1'b1);
      repeat (6) @(negedge clk_in);
      `CHK(data_oe, 8'hF8)
      `CHK(data_out[7], rdy)
      `CHK(rdy, 1'b1)
      host.strobes(1'b0, 1'b0, 1'b1);
      repeat (6) @(negedge clk_in);
      `CHK(data_oe, 8'h00)
      got.delete();
      host.strobes(1'b1, 1'b0, 1'b0);
      repeat (6) @(negedge clk_in);
      `CHK(data_oe, 8'h00)
      host.strobes(1'b0, 1'b1, 1'b1);
      repeat (8) @(negedge clk_in);
      `CHK(got.size(), 1)
      `CHK(got[0], 8'hFF)
   endtask

   // Sink stall fills the buffer, then drains in order
   task automatic t_backpressure();
      sink_ready = 1'b0;
      got.delete();
      host.write_byte(8'h01, 1'b1, 1'b1);
      host.write_byte(8'h02, 1'b1, 1'b1);
      host.write_byte(8'h03, 1'b1, 1'b0);
      repeat (10) @(negedge clk_in);
      `CHK(rdy, 1'b0)
      `CHK(got.size(), 0)
      sink_ready = 1'b1;
      repeat (10) @(negedge clk_in);
      `CHK({got[0], got[1], got[2]}, 24'h010203)
      `CHK(got.size(), 3)
      `CHK(rdy, 1'b1)
   endtask

   // Completion swaps the flags; scan functions stay on while selected, then drop
   task automatic t_done();
      bscan_sel = 1'b1;
      cfg_done = 1'b1;
      @(negedge clk_in);
      cfg_done = 1'b0;
      repeat (4) @(negedge clk_in);
      `CHK({flag_hi, flag_lo}, 2'b01)
      `CHK(bscan_en, 1'b1)
      bscan_sel = 1'b0;
      repeat (2) @(negedge clk_in);
      `CHK(bscan_en, 1'b0)
   endtask

   // Processor port reads and writes
   task automatic t_proc();
      start_cfg(4'h3);
      host.proc_xfer(1'b1, 18'h2A5C3, 1'b0);
      `CHK(req_cnt, 1)
      `CHK(req_rd, 1'b1)
      `CHK(req_addr, 18'h2A5C3)
      `CHK(req_burst, 1'b1)
      host.proc_xfer(1'b0, 18'h15A3C, 1'b1);
      `CHK(req_cnt, 2)
      `CHK(req_rd, 1'b0)
      `CHK(req_addr, 18'h15A3C)
      `CHK(req_burst, 1'b0)
   endtask

   // Master parallel read clock runs
   task automatic t_master();
      int edges;
      logic prev;
      edges = 0;
      start_cfg(4'h6);
      prev = rdy;
      repeat (30) begin
         @(negedge clk_in);
         if (rdy !== prev) edges++;
         prev = rdy;
      end
      `CHK(edges > 4, 1'b1)
   endtask

   // Verdict and end of run
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Watchdog well beyond the expected run
   initial begin
      repeat (5000) @(posedge clk_in);
      error_cnt++;
      print_verdict();
   end

   // Main sequence
   initial begin
      repeat (20) @(negedge clk_in);
      t_reset();
      srst_in = 1'b0;
      t_hold_write();
      t_status();
      t_backpressure();
      t_done();
      t_proc();
      t_master();
      print_verdict();
   end
endmodule
`default_nettype wire
